// file: design/bac_top.sv
// APB register bank for the bus area control register and its decoded outputs
//
// Behaviour
// - Strap captured on the first edge after reset release into bit 11, read-only.
// - Bit 11 zero big endian, one little.
// - Area 0 burst code: none, 4, 8, 16.
// - Area 5 burst code: none, 4, 8, 16.
// - Area 6 burst code: none, 4, 8, 16.
// - Memory type selects SDRAM for areas 2, 3.
// - Bit 1 puts area 5 in card space.
// - Bit 0 puts area 6 in card space.
// - Bus size codes 01, 10, 11; 00 prohibited.
`timescale 1ns/1ps
`default_nettype none
module bac_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic byte_order_strap_pin,
    output logic little_endian,
    output logic [4:0] area0_burst_count,
    output logic [4:0] area5_burst_count,
    output logic [4:0] area6_burst_count,
    output logic area2_sdram,
    output logic area3_sdram,
    output logic area5_card_space_sel,
    output logic area6_card_space_sel,
    output logic config_error
);
    bac_cfg_if cfg ();

    ////////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [10:0] ctrl_r;
    logic [10:0] ctrl_nxt;
    logic [7:0] size_r;
    logic [7:0] size_nxt;
    logic endian_r;
    logic endian_nxt;
    logic strap_done_r;
    logic strap_done_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic wr_en;
    logic rd_en;
    logic hit;

    always_comb begin
        hit = (paddr == bac_pkg::BAC_ADDR_CTRL1) || (paddr == bac_pkg::BAC_ADDR_BUS_SIZE)
            || (paddr == bac_pkg::BAC_ADDR_DECODE);
        wr_en = psel && penable && pwrite && hit;
        rd_en = psel && !penable && !pwrite;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte order strap

    always_comb begin
        endian_nxt = endian_r;
        strap_done_nxt = 1'b1;
        // Strap is caught on the first edge after reset release, never under reset
        if (!strap_done_r) begin
            endian_nxt = byte_order_strap_pin;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            endian_r <= 1'b0;
            strap_done_r <= 1'b0;
        end else begin
            endian_r <= endian_nxt;
            strap_done_r <= strap_done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_en && paddr == bac_pkg::BAC_ADDR_CTRL1) begin
            // Bit 11 sits outside the write mask so software cannot alter it
            if (pstrb[0]) begin
                ctrl_nxt[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                ctrl_nxt[10:8] = pwdata[10:8] & bac_pkg::BAC_CTRL1_WMASK[10:8];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= bac_pkg::BAC_CTRL1_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus size register

    always_comb begin
        size_nxt = size_r;
        if (wr_en && paddr == bac_pkg::BAC_ADDR_BUS_SIZE && pstrb[0]) begin
            size_nxt = pwdata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            size_r <= bac_pkg::BAC_SIZE_RESET;
        end else begin
            size_r <= size_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, loaded in the setup cycle so it stands through the access phase

    always_comb begin
        prdata_nxt = prdata_r;
        if (rd_en) begin
            case (paddr)
                bac_pkg::BAC_ADDR_CTRL1: prdata_nxt = {20'h00000, endian_r, ctrl_r};
                bac_pkg::BAC_ADDR_BUS_SIZE: prdata_nxt = {24'h000000, size_r};
                bac_pkg::BAC_ADDR_DECODE: prdata_nxt = {16'h0000, 7'h00, cfg.cfg_error,
                    cfg.a3_sdram, cfg.a2_sdram, cfg.a0_len, 1'b0};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_r <= 32'h00000000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer and decoded outputs

    always_comb begin
        pready = 1'b1;
        pslverr = psel && penable && !hit;
        prdata = prdata_r;
    end

    assign cfg.a0_burst = ctrl_r[bac_pkg::BAC_POS_A0_BST +: 2];
    assign cfg.a5_burst = ctrl_r[bac_pkg::BAC_POS_A5_BST +: 2];
    assign cfg.a6_burst = ctrl_r[bac_pkg::BAC_POS_A6_BST +: 2];
    assign cfg.memtype = ctrl_r[bac_pkg::BAC_POS_MEMTYPE +: 3];
    assign cfg.bus_size = size_r;

    bac_decode u_decode (
        .cfg(cfg)
    );

    assign little_endian = endian_r;
    assign area0_burst_count = cfg.a0_len;
    assign area5_burst_count = cfg.a5_len;
    assign area6_burst_count = cfg.a6_len;
    // SRAM use at 1:1 with SDRAM is software's duty; flagged via area3_sdram only
    assign area2_sdram = cfg.a2_sdram;
    assign area3_sdram = cfg.a3_sdram;
    assign area5_card_space_sel = ctrl_r[bac_pkg::BAC_POS_A5_CARD];
    assign area6_card_space_sel = ctrl_r[bac_pkg::BAC_POS_A6_CARD];
    assign config_error = cfg.cfg_error;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_strap_read_only: assert property (@(posedge mclk) disable iff (!reset_n)
        strap_done_r |=> $stable(endian_r))
        else $error("byte order bit changed after capture");
    a_strap_capture: assert property (@(posedge mclk) disable iff (!reset_n)
        !strap_done_r |=> endian_r == $past(byte_order_strap_pin))
        else $error("strap level not captured");
    a_endian_out: assert property (@(posedge mclk) disable iff (!reset_n)
        little_endian == prdata_nxt[11] || !(rd_en && paddr == bac_pkg::BAC_ADDR_CTRL1))
        else $error("endian readback mismatch");
    a_area0_len: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[10:9] == 2'b11 |-> area0_burst_count == 5'h10)
        else $error("area 0 burst of 16 wrong");
    a_area5_len: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[8:7] == 2'b10 |-> area5_burst_count == 5'h08)
        else $error("area 5 burst of 8 wrong");
    a_area6_len: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[6:5] == 2'b00 |-> area6_burst_count == 5'h00)
        else $error("area 6 ordinary access wrong");
    a_memtype_map: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[4:2] == 3'b010 |-> area3_sdram && !area2_sdram)
        else $error("memory type 010 misdecoded");
    a_card5_write: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_en && paddr == bac_pkg::BAC_ADDR_CTRL1 && pstrb[0]
        |=> area5_card_space_sel == $past(pwdata[1]))
        else $error("area 5 bus type not written");
    a_card6_write: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_en && paddr == bac_pkg::BAC_ADDR_CTRL1 && pstrb[0]
        |=> area6_card_space_sel == $past(pwdata[0]))
        else $error("area 6 bus type not written");
    a_reset_clear: assert property (@(posedge mclk)
        $rose(reset_n) |-> ctrl_r == 11'h000)
        else $error("control fields not clear after reset");

    // Burst and memory type decode, one assertion for each code not already checked above
    a_area0_ord: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[10:9] == 2'b00 |-> area0_burst_count == 5'h00)
        else $error("area 0 ordinary access wrong");
    a_area0_four: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[10:9] == 2'b01 |-> area0_burst_count == 5'h04)
        else $error("area 0 burst of 4 wrong");
    a_area0_eight: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[10:9] == 2'b10 |-> area0_burst_count == 5'h08)
        else $error("area 0 burst of 8 wrong");
    a_area5_ord: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[8:7] == 2'b00 |-> area5_burst_count == 5'h00)
        else $error("area 5 ordinary access wrong");
    a_area5_four: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[8:7] == 2'b01 |-> area5_burst_count == 5'h04)
        else $error("area 5 burst of 4 wrong");
    a_area5_sixteen: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[8:7] == 2'b11 |-> area5_burst_count == 5'h10)
        else $error("area 5 burst of 16 wrong");
    a_area6_four: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[6:5] == 2'b01 |-> area6_burst_count == 5'h04)
        else $error("area 6 burst of 4 wrong");
    a_area6_eight: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[6:5] == 2'b10 |-> area6_burst_count == 5'h08)
        else $error("area 6 burst of 8 wrong");
    a_area6_sixteen: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[6:5] == 2'b11 |-> area6_burst_count == 5'h10)
        else $error("area 6 burst of 16 wrong");
    a_memtype_ord: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[4:2] == 3'b000 |-> !area2_sdram && !area3_sdram)
        else $error("memory type 000 misdecoded");
    a_memtype_both: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[4:2] == 3'b011 |-> area2_sdram && area3_sdram)
        else $error("memory type 011 misdecoded");

    // Misuse is flagged only; the stored code still drives the decode
    a_memtype_flag: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[4:2] != 3'b000 && ctrl_r[4:2] != 3'b010 && ctrl_r[4:2] != 3'b011 |-> config_error)
        else $error("prohibited memory type not flagged");
    a_sdram_width: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_r[4:2] == 3'b011 && size_r[1:0] != size_r[3:2] |-> config_error)
        else $error("unequal SDRAM widths not flagged");
    a_size_code: assert property (@(posedge mclk) disable iff (!reset_n)
        size_r[1:0] == 2'b00 || size_r[3:2] == 2'b00 || size_r[5:4] == 2'b00
        || size_r[7:6] == 2'b00 |-> config_error)
        else $error("prohibited bus size not flagged");
    a_burst_width: assert property (@(posedge mclk) disable iff (!reset_n)
        (ctrl_r[8:7] == 2'b11 && size_r[5:4] != 2'b01)
        || (ctrl_r[6:5] == 2'b11 && size_r[7:6] != 2'b01) |-> config_error)
        else $error("burst of 16 on wide bus not flagged");

    // Register writes and holds
    a_ctrl_write_low: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_en && paddr == bac_pkg::BAC_ADDR_CTRL1 && pstrb[0]
        |=> ctrl_r[7:0] == $past(pwdata[7:0]))
        else $error("control low byte not written");
    a_ctrl_write_high: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_en && paddr == bac_pkg::BAC_ADDR_CTRL1 && pstrb[1]
        |=> ctrl_r[10:8] == $past(pwdata[10:8]))
        else $error("control high bits not written");
    a_ctrl_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        !(wr_en && paddr == bac_pkg::BAC_ADDR_CTRL1) |=> $stable(ctrl_r))
        else $error("control changed without a write");
    a_size_write: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_en && paddr == bac_pkg::BAC_ADDR_BUS_SIZE && pstrb[0]
        |=> size_r == $past(pwdata[7:0]))
        else $error("bus size register not written");
    a_card5_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        !(wr_en && paddr == bac_pkg::BAC_ADDR_CTRL1 && pstrb[0])
        |=> $stable(area5_card_space_sel))
        else $error("area 5 bus type changed without a write");
    a_card6_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        !(wr_en && paddr == bac_pkg::BAC_ADDR_CTRL1 && pstrb[0])
        |=> $stable(area6_card_space_sel))
        else $error("area 6 bus type changed without a write");

    // Read data
    a_read_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        !rd_en |=> $stable(prdata))
        else $error("read data changed outside a read setup");
    a_endian_read: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_en && paddr == bac_pkg::BAC_ADDR_CTRL1 |=> prdata[11] == $past(little_endian))
        else $error("byte order bit not read back");
    a_decode_read: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_en && paddr == bac_pkg::BAC_ADDR_DECODE
        |=> prdata[7] == $past(area3_sdram) && prdata[6] == $past(area2_sdram))
        else $error("decode register readback wrong");
    a_unmapped_read: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_en && !hit |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");

    // Reset
    a_reset_outputs: assert property (@(posedge mclk)
        $rose(reset_n) |-> !area2_sdram && !area3_sdram && !area5_card_space_sel
            && !area6_card_space_sel && area0_burst_count == 5'h00)
        else $error("decoded outputs not clear after reset");
endmodule
`default_nettype wire

// file: pkg/bac_pkg.sv
// Package with offsets, field positions and codes of the bus area control block
package bac_pkg;
    localparam logic [7:0] BAC_ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] BAC_ADDR_BUS_SIZE = 8'h04;
    localparam logic [7:0] BAC_ADDR_DECODE = 8'h08;
    localparam int BAC_POS_ENDIAN = 11;
    localparam int BAC_POS_A0_BST = 9;
    localparam int BAC_POS_A5_BST = 7;
    localparam int BAC_POS_A6_BST = 5;
    localparam int BAC_POS_MEMTYPE = 2;
    localparam int BAC_POS_A5_CARD = 1;
    localparam int BAC_POS_A6_CARD = 0;
    localparam int BAC_POS_A2_SIZE = 0;
    localparam int BAC_POS_A3_SIZE = 2;
    localparam int BAC_POS_A5_SIZE = 4;
    localparam int BAC_POS_A6_SIZE = 6;
    localparam logic [10:0] BAC_CTRL1_RESET = 11'h000;
    localparam logic [7:0] BAC_SIZE_RESET = 8'hff;
    localparam logic [10:0] BAC_CTRL1_WMASK = 11'h7ff;
    typedef enum logic [1:0] {
        BAC_BST_NONE = 2'b00,
        BAC_BST_4 = 2'b01,
        BAC_BST_8 = 2'b10,
        BAC_BST_16 = 2'b11
    } bac_burst_e;
    typedef enum logic [2:0] {
        BAC_MT_ORD = 3'b000,
        BAC_MT_A3_SDRAM = 3'b010,
        BAC_MT_BOTH_SDRAM = 3'b011
    } bac_memtype_e;
    typedef enum logic [1:0] {
        BAC_SZ_BAD = 2'b00,
        BAC_SZ_8 = 2'b01,
        BAC_SZ_16 = 2'b10,
        BAC_SZ_32 = 2'b11
    } bac_size_e;
endpackage

// file: pkg/bac_cfg_if.sv
// Interface carrying decoded area configuration between the register bank and decoder
`timescale 1ns/1ps
`default_nettype none
interface bac_cfg_if;
    logic [1:0] a0_burst;
    logic [1:0] a5_burst;
    logic [1:0] a6_burst;
    logic [2:0] memtype;
    logic [7:0] bus_size;
    logic [4:0] a0_len;
    logic [4:0] a5_len;
    logic [4:0] a6_len;
    logic a2_sdram;
    logic a3_sdram;
    logic cfg_error;
    modport bank (output a0_burst, a5_burst, a6_burst, memtype, bus_size,
        input a0_len, a5_len, a6_len, a2_sdram, a3_sdram, cfg_error);
    modport dec (input a0_burst, a5_burst, a6_burst, memtype, bus_size,
        output a0_len, a5_len, a6_len, a2_sdram, a3_sdram, cfg_error);
endinterface
`default_nettype wire

// file: design/bac_decode.sv
// Decoder turning burst, memory type and bus size codes into per-area settings
`timescale 1ns/1ps
`default_nettype none
module bac_decode (
    bac_cfg_if.dec cfg
);
    // Burst code to number of consecutive accesses, zero for ordinary access
    function automatic logic [4:0] burst_len(input logic [1:0] code);
        case (code)
            bac_pkg::BAC_BST_4: burst_len = 5'h04;
            bac_pkg::BAC_BST_8: burst_len = 5'h08;
            bac_pkg::BAC_BST_16: burst_len = 5'h10;
            default: burst_len = 5'h00;
        endcase
    endfunction

    // Burst length allowed for the given bus size code
    function automatic logic burst_ok(input logic [1:0] code, input logic [1:0] sz);
        case (code)
            bac_pkg::BAC_BST_4: burst_ok = (sz != bac_pkg::BAC_SZ_BAD);
            bac_pkg::BAC_BST_8: burst_ok = (sz == bac_pkg::BAC_SZ_8) || (sz == bac_pkg::BAC_SZ_16);
            bac_pkg::BAC_BST_16: burst_ok = (sz == bac_pkg::BAC_SZ_8);
            default: burst_ok = 1'b1;
        endcase
    endfunction

    logic [1:0] sz2;
    logic [1:0] sz3;
    logic [1:0] sz5;
    logic [1:0] sz6;
    logic mt_bad;

    always_comb begin
        sz2 = cfg.bus_size[bac_pkg::BAC_POS_A2_SIZE +: 2];
        sz3 = cfg.bus_size[bac_pkg::BAC_POS_A3_SIZE +: 2];
        sz5 = cfg.bus_size[bac_pkg::BAC_POS_A5_SIZE +: 2];
        sz6 = cfg.bus_size[bac_pkg::BAC_POS_A6_SIZE +: 2];
        cfg.a0_len = burst_len(cfg.a0_burst);
        cfg.a5_len = burst_len(cfg.a5_burst);
        cfg.a6_len = burst_len(cfg.a6_burst);
        cfg.a2_sdram = (cfg.memtype == bac_pkg::BAC_MT_BOTH_SDRAM);
        cfg.a3_sdram = (cfg.memtype == bac_pkg::BAC_MT_BOTH_SDRAM)
            || (cfg.memtype == bac_pkg::BAC_MT_A3_SDRAM);
        mt_bad = !(cfg.a3_sdram || cfg.memtype == bac_pkg::BAC_MT_ORD);
        // Misuse is only flagged; the hardware still takes the code as written
        cfg.cfg_error = mt_bad
            || !burst_ok(cfg.a5_burst, sz5)
            || !burst_ok(cfg.a6_burst, sz6)
            || (cfg.a2_sdram && sz2 != sz3)
            || sz2 == bac_pkg::BAC_SZ_BAD || sz3 == bac_pkg::BAC_SZ_BAD
            || sz5 == bac_pkg::BAC_SZ_BAD || sz6 == bac_pkg::BAC_SZ_BAD;
    end
endmodule
`default_nettype wire

// file: test/bac_strap_model.sv
// Board strap model that sets the byte order level seen at power-on reset
`timescale 1ns/1ps
`default_nettype none
module bac_strap_model (
    input wire logic drive_high,
    output logic byte_order_strap_pin
);
    // A resistor strap holds a steady level, so the pin never floats
    assign byte_order_strap_pin = drive_high;
endmodule
`default_nettype wire

// file: test/tb_bus_area_config_control.sv
// Self-checking bench for the bus area control register block
`timescale 1ns/1ps
`default_nettype none
module tb_bus_area_config_control;
    typedef struct packed {
        logic [10:0] w;
        logic [4:0] c0;
        logic [4:0] c5;
        logic [4:0] c6;
        logic s2;
        logic s3;
    } bac_row_s;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic strap_hi = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, strap, little_endian, sd2, sd3, cs5, cs6, cfg_err;
    logic [4:0] cnt0, cnt5, cnt6;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    bac_row_s rows [4] = '{
        '{11'h000, 5'h00, 5'h00, 5'h00, 1'b0, 1'b0},
        '{11'h360, 5'h04, 5'h08, 5'h10, 1'b0, 1'b0},
        '{11'h5aa, 5'h08, 5'h10, 5'h04, 1'b0, 1'b1},
        '{11'h6cd, 5'h10, 5'h04, 5'h08, 1'b1, 1'b1}};

    always #4 mclk = ~mclk;

    bac_strap_model bac_strap_model_inst (.drive_high(strap_hi), .byte_order_strap_pin(strap));
    bac_top bac_top_inst (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .byte_order_strap_pin(strap),
        .little_endian(little_endian), .area0_burst_count(cnt0), .area5_burst_count(cnt5),
        .area6_burst_count(cnt6), .area2_sdram(sd2), .area3_sdram(sd3),
        .area5_card_space_sel(cs5), .area6_card_space_sel(cs6), .config_error(cfg_err));

////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Caller stands just after a rising edge; leaves one idle edge after the access
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Ends on the first edge that sees pready high
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic do_reset(input logic hi);
        strap_hi <= hi;
        reset_n <= 1'b0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

////////////////////////////////////////////////////////////////////////////////
    // Whole run needs about 100 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        do_reset(1'b0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, little_endian}, 32'h0);
        chk({22'h0, cnt0, cnt5}, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            // Bit 11 is always written as one to prove it is ignored
            apb(1'b1, 8'h00, {20'h0, 1'b1, rows[i].w});
            apb(1'b0, 8'h00, 32'h0);
            chk(rd, {21'h0, rows[i].w});
            chk({27'h0, cnt0}, {27'h0, rows[i].c0});
            chk({27'h0, cnt5}, {27'h0, rows[i].c5});
            chk({27'h0, cnt6}, {27'h0, rows[i].c6});
            chk({30'h0, sd2, sd3}, {30'h0, rows[i].s2, rows[i].s3});
            chk({30'h0, cs5, cs6}, {30'h0, rows[i].w[1:0]});
        end
        $display("test rows done");
        apb(1'b1, 8'h0c, 32'h7ff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h6cd);
        $display("test unmapped done");
        apb(1'b1, 8'h00, 32'h4);
        chk({31'h0, cfg_err}, 32'h1);
        apb(1'b1, 8'h00, 32'h10);
        chk({31'h0, cfg_err}, 32'h1);
        apb(1'b1, 8'h04, 32'hdf);
        apb(1'b1, 8'h00, 32'h180);
        chk({31'h0, cfg_err}, 32'h0);
        apb(1'b1, 8'h00, 32'h60);
        chk({31'h0, cfg_err}, 32'h1);
        apb(1'b1, 8'h00, 32'hc);
        chk({31'h0, cfg_err}, 32'h0);
        apb(1'b1, 8'h04, 32'hf7);
        chk({31'h0, cfg_err}, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h1c0);
        apb(1'b1, 8'h04, 32'hf0);
        chk({31'h0, cfg_err}, 32'h1);
        // Upper lane only: the low byte must keep its value
        pstrb <= 4'h2;
        apb(1'b1, 8'h00, 32'hfff);
        pstrb <= 4'hf;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h70c);
        $display("test prohibited done");
        do_reset(1'b1);
        chk({31'h0, little_endian}, 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h800);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, {24'h0, bac_pkg::BAC_SIZE_RESET});
        $display("test strap done");
        complete_run();
    end
endmodule
`default_nettype wire
